/* verilog/ssm_top.sv */
// signal-strength measurement control with its spi register port
// assumes rxOn, adcDone and adcData come from core_clk logic; spi pins and carrierSense are asynchronous
// How it works
// - a read of the strength register returns the latest on-channel power reading.
// - a carrier held above the noise floor for over 50 us starts a conversion on its own.
// - a finished conversion puts the 5-bit value in bits 4:0 and sets the valid flag in bit 5.
// - after one conversion the machine halts until the receiver is switched off and on again.
// - setting bit 7 of the override register acts as a detected carrier and starts a conversion.
`default_nettype none
module ssm_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiSck,
  input wire logic spiMosi,
  input wire logic spiSsN,
  output logic spiMiso,
  input wire logic rxOn,
  input wire logic carrierSense,
  output logic adcStart,
  input wire logic adcDone,
  input wire logic [ssm_pkg::STRENGTH_W-1:0] adcData
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic sckS, mosiS, ssNS, carrierS, sckPrev;
  ssm_sync #(.WIDTH(4)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({spiSck, spiMosi, spiSsN, carrierSense}),
    .q({sckS, mosiS, ssNS, carrierS})
  );

  ////////////////////////////////////////////////////////////////////////////
  // spi slave: mode 0, command byte then data bytes
  logic [2:0] bitCnt;
  logic firstByte, isWrite, autoInc;
  logic [5:0] addr;
  logic [6:0] rxShift;
  logic [7:0] txShift;
  logic [7:0] cdOverride;
  logic [ssm_pkg::STRENGTH_W-1:0] strengthValue;
  logic strengthValid;
  ssm_pkg::ssm_state_e state, next_state;
  logic [ssm_pkg::CD_CNT_W-1:0] cdCount;

  wire spiActive = ~ssNS;
  wire sckRise = sckS & ~sckPrev;
  wire sckFall = ~sckS & sckPrev;
  wire [7:0] rxByte = {rxShift, mosiS};
  wire byteDone = spiActive & sckRise & (bitCnt == 3'h7);
  wire cmdDone = byteDone & firstByte;
  wire dataDone = byteDone & ~firstByte;
  wire [5:0] cmdAddr = rxByte[5:0];
  wire [5:0] stepAddr = autoInc ? 6'(addr + 6'h01) : addr;
  wire [5:0] loadAddr = cmdDone ? cmdAddr : stepAddr;
  wire loadIsWrite = cmdDone ? rxByte[ssm_pkg::CMD_DIR_BIT] : isWrite;
  wire [7:0] strengthByte = {2'b00, strengthValid, strengthValue};
  // unmapped addresses read as zero; only the two measurement registers live here
  wire [7:0] loadData = (loadAddr == ssm_pkg::SIG_STRENGTH_ADDR) ? strengthByte :
                        (loadAddr == ssm_pkg::CD_OVERRIDE_ADDR) ? cdOverride : ssm_pkg::READ_ZERO;
  wire ovrWrite = dataDone & isWrite & (addr == ssm_pkg::CD_OVERRIDE_ADDR);
  wire forceCd = cdOverride[ssm_pkg::CD_OVERRIDE_BIT];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sckPrev <= 1'b0;
      bitCnt <= 3'h0;
      firstByte <= 1'b1;
      isWrite <= 1'b0;
      autoInc <= 1'b0;
      addr <= 6'h00;
      rxShift <= 7'h00;
    end else begin
      sckPrev <= sckS;
      if (!spiActive) begin
        bitCnt <= 3'h0;
        firstByte <= 1'b1;
      end else if (sckRise) begin
        rxShift <= rxByte[6:0];
        bitCnt <= 3'(bitCnt + 3'h1);
        if (cmdDone) begin
          firstByte <= 1'b0;
          isWrite <= rxByte[ssm_pkg::CMD_DIR_BIT];
          autoInc <= rxByte[ssm_pkg::CMD_INC_BIT];
          addr <= cmdAddr;
        end else if (dataDone) begin
          addr <= stepAddr;
        end
      end
    end
  end

  // read data is loaded at the end of each byte so bit 7 is out before the next rising sck
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txShift <= 8'h00;
      spiMiso <= 1'b0;
    end else if (byteDone && !loadIsWrite) begin
      txShift <= loadData;
    end else if (spiActive && sckFall) begin
      spiMiso <= txShift[7];
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cdOverride <= ssm_pkg::CD_OVERRIDE_RESET;
    end else if (ovrWrite) begin
      cdOverride <= rxByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement state machine
  wire cdPersisted = carrierS & (cdCount == ssm_pkg::CD_LIMIT);
  always_comb begin
    next_state = state;
    case (state)
      ssm_pkg::ST_OFF: begin
        if (rxOn) next_state = ssm_pkg::ST_ARMED;
      end
      ssm_pkg::ST_ARMED: begin
        if (!rxOn) next_state = ssm_pkg::ST_OFF;
        else if (forceCd || cdPersisted) next_state = ssm_pkg::ST_CONVERT;
      end
      ssm_pkg::ST_CONVERT: begin
        if (adcDone) next_state = ssm_pkg::ST_HALT;
        else if (!rxOn) next_state = ssm_pkg::ST_OFF;
      end
      ssm_pkg::ST_HALT: begin
        // no retrigger here, neither by carrier nor override
        if (!rxOn) next_state = ssm_pkg::ST_OFF;
      end
      default: next_state = ssm_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ssm_pkg::ST_OFF;
      cdCount <= '0;
      adcStart <= 1'b0;
      strengthValue <= '0;
      strengthValid <= 1'b0;
    end else begin
      state <= next_state;
      // counter saturates so a long carrier cannot wrap back to zero
      if (!carrierS || state != ssm_pkg::ST_ARMED) cdCount <= '0;
      else if (cdCount != ssm_pkg::CD_LIMIT) cdCount <= ssm_pkg::CD_CNT_W'(cdCount + 1'b1);
      adcStart <= (state == ssm_pkg::ST_ARMED) && (next_state == ssm_pkg::ST_CONVERT);
      if (state == ssm_pkg::ST_OFF && rxOn) begin
        strengthValid <= 1'b0;
      end else if (state == ssm_pkg::ST_CONVERT && adcDone) begin
        strengthValue <= adcData;
        strengthValid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_read_strength;
    @(posedge core_clk) disable iff (rst)
    (cmdDone && !rxByte[ssm_pkg::CMD_DIR_BIT] && cmdAddr == ssm_pkg::SIG_STRENGTH_ADDR)
      |=> txShift == {2'b00, $past(strengthValid), $past(strengthValue)};
  endproperty
  a_read_strength: assert property (p_read_strength) else $error("strength read loads wrong byte");

  property p_carrier_start;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_ARMED && rxOn && !forceCd && carrierS && cdCount == ssm_pkg::CD_LIMIT)
      |=> (state == ssm_pkg::ST_CONVERT) && adcStart;
  endproperty
  a_carrier_start: assert property (p_carrier_start) else $error("persistent carrier did not start");

  property p_no_early_start;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_ARMED && !forceCd && cdCount != ssm_pkg::CD_LIMIT) |=> state != ssm_pkg::ST_CONVERT;
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("conversion began before 50 us");

  property p_latch_result;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_CONVERT && adcDone)
      |=> strengthValid && strengthValue == $past(adcData) && state == ssm_pkg::ST_HALT;
  endproperty
  a_latch_result: assert property (p_latch_result) else $error("conversion result not latched");

  property p_halt_holds;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_HALT && rxOn) |=> (state == ssm_pkg::ST_HALT) && !adcStart;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt left while receiver on");

  property p_force_start;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_ARMED && rxOn && forceCd) |=> adcStart ##1 !adcStart;
  endproperty
  a_force_start: assert property (p_force_start) else $error("override did not start one conversion");

  property p_rearm;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_OFF && rxOn) |=> (state == ssm_pkg::ST_ARMED) && !strengthValid;
  endproperty
  a_rearm: assert property (p_rearm) else $error("receive entry did not re-arm");

  property p_override_write;
    @(posedge core_clk) disable iff (rst)
    ovrWrite |=> cdOverride == $past(rxByte);
  endproperty
  a_override_write: assert property (p_override_write) else $error("override write not stored");

  property p_single_start;
    @(posedge core_clk) disable iff (rst)
    adcStart |-> (state == ssm_pkg::ST_CONVERT) ##1 !adcStart;
  endproperty
  a_single_start: assert property (p_single_start) else $error("start pulse not single");

  // a conversion cut short by switching off must not leave a valid flag behind
  property p_abandon;
    @(posedge core_clk) disable iff (rst)
    (state == ssm_pkg::ST_CONVERT && !rxOn && !adcDone) |=> (state == ssm_pkg::ST_OFF) && $stable(strengthValid);
  endproperty
  a_abandon: assert property (p_abandon) else $error("abandoned conversion touched valid");
endmodule
`default_nettype wire

/* verilog/ssm_pkg.sv */
// constants for the signal-strength measurement block
// assumes a single 20 MHz core clock and a spi-style register port
`default_nettype none
package ssm_pkg;
  // register map (6-bit spi address space)
  localparam logic [5:0] SIG_STRENGTH_ADDR = 6'h22;
  localparam logic [5:0] CD_OVERRIDE_ADDR = 6'h2f;
  localparam logic [7:0] CD_OVERRIDE_RESET = 8'h00;
  localparam int CD_OVERRIDE_BIT = 7;
  localparam int STRENGTH_W = 5;
  localparam int VALID_BIT = 5;
  // spi command byte layout
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_INC_BIT = 6;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // carrier persistence time before an automatic conversion
  localparam int CD_TIME_US = 50;
  localparam int CLK_FREQ_MHZ = 20;
  localparam int CD_CYCLES = CD_TIME_US * CLK_FREQ_MHZ;
  localparam int CD_CNT_W = 11;
  localparam logic [CD_CNT_W-1:0] CD_LIMIT = CD_CNT_W'(CD_CYCLES);
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONVERT = 2'b10,
    ST_HALT = 2'b11
  } ssm_state_e;
endpackage
`default_nettype wire

/* verilog/ssm_sync.sv */
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no bus coherence across bits
`default_nettype none
module ssm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* sim/ssm_top_test.sv */
// bench for the signal-strength measurement block: spi register port, receiver and adc handshake
// assumes ssm_top as declared, a 50 ns core clock; this bench plays the host, receiver and adc
`default_nettype none
module ssm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic spiSck = 1'b0;
  logic spiMosi = 1'b0;
  logic spiSsN = 1'b1;
  logic rxOn = 1'b0;
  logic carrierSense = 1'b0;
  logic adcDone = 1'b0;
  logic [ssm_pkg::STRENGTH_W-1:0] adcData = 5'h00;
  wire logic spiMiso;
  wire logic adcStart;
  int failures = 0;
  int n_tests = 0;
  int starts = 0;
  int n;
  int sum = 0;
  logic [7:0] rdata;
  always #25 core_clk = ~core_clk;
  ssm_top uut (.core_clk(core_clk), .rst(rst), .spiSck(spiSck), .spiMosi(spiMosi), .spiSsN(spiSsN),
    .spiMiso(spiMiso), .rxOn(rxOn), .carrierSense(carrierSense), .adcStart(adcStart), .adcDone(adcDone),
    .adcData(adcData));
  always @(posedge core_clk) if (adcStart === 1'b1) starts++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  // half period of 10 core clocks leaves room for the 2-flop pin synchronisers
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiMosi = tx[i];
      ticks(10);
      rx[i] = spiMiso;
      spiSck = 1'b1;
      ticks(10);
      spiSck = 1'b0;
    end
  endtask
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    spiSsN = 1'b0;
    xfer({wr, 1'b0, addr}, junk);
    xfer(wd, rd);
    ticks(10);
    spiSsN = 1'b1;
    ticks(10);
  endtask
  task automatic waitStart(input int limit);
    n = 0;
    while (adcStart !== 1'b1) begin
      if (n >= limit) begin
        failures++;
        $display("CHECK FAILED at %0t: expected %h got %h", $time, 1'b1, adcStart);
        summarize();
      end else begin
        ticks(1);
        n++;
      end
    end
  endtask
  task automatic convert(input logic [4:0] v);
    adcData = v;
    adcDone = 1'b1;
    ticks(1);
    adcDone = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ticks(3);
    rst = 1'b0;
    ticks(2);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h00, rdata);
    access(1'b0, ssm_pkg::CD_OVERRIDE_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(ssm_pkg::CD_OVERRIDE_RESET, rdata);
    access(1'b0, 6'h10, ssm_pkg::READ_ZERO, rdata);
    check(8'h00, rdata);
    // the strength register is read only
    access(1'b1, ssm_pkg::SIG_STRENGTH_ADDR, 8'h3f, rdata);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h00, rdata);
    rxOn = 1'b1;
    ticks(2);
    access(1'b1, ssm_pkg::CD_OVERRIDE_ADDR, 8'h80, rdata);
    check(8'h01, 8'(starts));
    convert(5'h0a);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h2a, rdata);
    access(1'b0, ssm_pkg::CD_OVERRIDE_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h80, rdata);
    // halted: a held carrier and the set override must not restart it
    carrierSense = 1'b1;
    ticks(1100);
    check(8'h01, 8'(starts));
    access(1'b1, ssm_pkg::CD_OVERRIDE_ADDR, 8'h00, rdata);
    carrierSense = 1'b0;
    rxOn = 1'b0;
    ticks(4);
    rxOn = 1'b1;
    ticks(4);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h0a, rdata);
    carrierSense = 1'b1;
    waitStart(1100);
    check(8'h01, 8'(n >= 1000 && n <= 1010));
    convert(5'h1f);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h3f, rdata);
    check(8'h01, 8'(rdata[4:0] > 5'h1c));
    // a conversion abandoned by switching off leaves the cleared flag alone
    rxOn = 1'b0;
    ticks(4);
    rxOn = 1'b1;
    waitStart(1100);
    rxOn = 1'b0;
    ticks(1);
    convert(5'h05);
    access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
    check(8'h1f, rdata);
    // quiet-channel estimate: forced readings averaged over twenty receive periods
    carrierSense = 1'b0;
    for (int i = 0; i < 20; i++) begin
      rxOn = 1'b1;
      ticks(2);
      access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
      check(8'h00, {7'h00, rdata[ssm_pkg::VALID_BIT]});
      access(1'b1, ssm_pkg::CD_OVERRIDE_ADDR, 8'h80, rdata);
      convert(5'(i % 8));
      ticks(1001);
      access(1'b0, ssm_pkg::SIG_STRENGTH_ADDR, ssm_pkg::READ_ZERO, rdata);
      check({3'h1, 5'(i % 8)}, rdata);
      sum += rdata[4:0];
      access(1'b1, ssm_pkg::CD_OVERRIDE_ADDR, 8'h00, rdata);
      rxOn = 1'b0;
      ticks(4);
    end
    check(8'h3e, 8'(sum));
    check(8'h01, 8'(sum / 32'h14 <= 32'h0a));
    summarize();
  end
endmodule
`default_nettype wire
